// ==== common/bridge_cap_pkg.sv ====
package bridge_cap_pkg;

    // Word offsets of the capability structures
    localparam logic [7:0] SUBSYS_CAP_OFFSET = 8'ha8;
    localparam logic [7:0] SUBSYS_ID_OFFSET = 8'hac;
    localparam logic [7:0] EXPRESS_CAP_OFFSET = 8'hb0;
    // Local control and status words
    localparam logic [7:0] CAP_CONTROL_OFFSET = 8'hc0;
    localparam logic [7:0] CAP_STATUS_OFFSET = 8'hc4;

    // Fixed field values
    localparam logic [7:0] SUBSYS_CAP_ID = 8'h0d;
    localparam logic [7:0] NEXT_LINK_EXPRESS = 8'hb0;
    localparam logic [7:0] NEXT_LINK_SLOT_IDENT = 8'ha0;
    localparam logic [7:0] EXPRESS_CAP_ID = 8'h10;
    localparam logic [7:0] EXPRESS_NEXT_LINK = 8'hf0;
    localparam logic [3:0] EXPRESS_CAP_VERSION = 4'h1;
    localparam logic [4:0] INT_MSG_NUMBER = 5'h00;
    localparam logic [1:0] EXPRESS_RSVD = 2'h0;
    localparam logic [15:0] SUBSYS_RSVD = 16'h0000;
    localparam logic SLOT_FORWARD = 1'b0;
    localparam logic SLOT_REVERSE = 1'b1;

    // Field positions in the local words
    localparam int CTRL_SLOT_IDENT_BIT = 0;
    localparam int STATUS_REVERSE_BIT = 0;
    localparam int STATUS_LATCHED_BIT = 1;

    // Reset values and strap timing
    localparam logic CTRL_SLOT_IDENT_RESET = 1'b0;
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

    typedef enum logic [3:0] {
        PORT_ENDPOINT = 4'h0,
        PORT_LEGACY_ENDPOINT = 4'h1,
        PORT_ROOT = 4'h4,
        PORT_SWITCH_UP = 4'h5,
        PORT_SWITCH_DOWN = 4'h6,
        PORT_EXPRESS_TO_CONV = 4'h7,
        PORT_CONV_TO_EXPRESS = 4'h8
    } port_type_t;

    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

    typedef struct packed {
        logic [15:0] reserved;
        logic [7:0] next_link;
        logic [7:0] cap_id;
    } subsys_word_t;

    typedef struct packed {
        logic [1:0] reserved;
        logic [4:0] msg_number;
        logic slot_implemented;
        port_type_t port_type;
        logic [3:0] version;
        logic [7:0] next_link;
        logic [7:0] cap_id;
    } express_word_t;

endpackage

// ==== design/bridge_capability_headers.sv ====
// Added by the designer: the APB register port.
`timescale 1ns/10ps
// Functional notes
// [RULE1] Subsystem capability identifier reads 0Dh and ignores writes.
// [RULE2] Its next link reads B0h, or A0h with slot identification enabled.
// [RULE3] Low half of word ACh holds the read-only subsystem vendor code.
// [RULE4] High half of word ACh holds the read-only subsystem code.
// [RULE5] Express capability identifier at B0h reads 10h, writes ignored.
// [RULE6] Express next link at B0h reads F0h, read-only.
// [RULE7] Port type codes as listed; other codes are reserved.
// [RULE8] Port type reads 7h forward, 8h reverse, from the strap.
// [RULE9] Slot implemented bit reads 0 forward, 1 reverse, read-only.
// [RULE10] Writes leave every capability field unchanged; a write to C0h still switches the A8h next link between B0h and A0h.
// [RULE11] Reserved bits read zero, version 1h, message number 0h.
module bridge_capability_headers #(
    // Arbitrary identity values
    parameter logic [15:0] SUBSYS_VENDOR_CODE = 16'h5a17,
    parameter logic [15:0] SUBSYS_CODE = 16'h0c3e
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic reverse_strap,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic reverse_active,
    output logic slot_ident_active
);

    logic strap_meta;
    logic strap_sync;
    logic [1:0] settle_count;
    logic strap_latched;
    logic slot_ident_en;
    bridge_cap_pkg::bus_state_t bus_state;
    bridge_cap_pkg::bus_state_t next_bus_state;
    bridge_cap_pkg::subsys_word_t subsys_word;
    bridge_cap_pkg::express_word_t express_word;
    logic [31:0] subsys_id_word;
    logic [31:0] control_word;
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    logic next_slverr;
    logic setup_phase;
    logic access_done;
    logic write_done;

    // Strap pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_meta <= 1'b0;
            strap_sync <= 1'b0;
        end else begin
            strap_meta <= reverse_strap;
            strap_sync <= strap_meta;
        end
    end

    // Strap caught once after the synchroniser has settled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_count <= 2'h0;
            strap_latched <= 1'b0;
            reverse_active <= 1'b0;
        end else if (!strap_latched) begin
            if (settle_count == bridge_cap_pkg::STRAP_SETTLE_CYCLES) begin
                strap_latched <= 1'b1;
                reverse_active <= strap_sync; // [RULE8]
            end else begin
                settle_count <= settle_count + 2'h1;
            end
        end
    end

    // Bus phases
    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign write_done = access_done && pwrite;

    // Local control word: slot identification enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_ident_en <= bridge_cap_pkg::CTRL_SLOT_IDENT_RESET;
        end else if (write_done && pstrb[0] &&
                     paddr == bridge_cap_pkg::CAP_CONTROL_OFFSET) begin
            slot_ident_en <=
                pwdata[bridge_cap_pkg::CTRL_SLOT_IDENT_BIT]; // [RULE2]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slot_ident_active <= bridge_cap_pkg::CTRL_SLOT_IDENT_RESET;
        end else begin
            slot_ident_active <= slot_ident_en;
        end
    end

    // Capability words, built from constants, the strap and the slot identification enable
    always_comb begin
        subsys_word.reserved = bridge_cap_pkg::SUBSYS_RSVD; // [RULE11]
        subsys_word.cap_id = bridge_cap_pkg::SUBSYS_CAP_ID; // [RULE1]
        subsys_word.next_link = slot_ident_en ?
            bridge_cap_pkg::NEXT_LINK_SLOT_IDENT :
            bridge_cap_pkg::NEXT_LINK_EXPRESS; // [RULE2]
    end

    // [RULE3]
    // [RULE4]
    assign subsys_id_word = {SUBSYS_CODE, SUBSYS_VENDOR_CODE};

    always_comb begin
        express_word.reserved = bridge_cap_pkg::EXPRESS_RSVD; // [RULE11]
        express_word.msg_number = bridge_cap_pkg::INT_MSG_NUMBER; // [RULE11]
        express_word.version = bridge_cap_pkg::EXPRESS_CAP_VERSION; // [RULE11]
        express_word.cap_id = bridge_cap_pkg::EXPRESS_CAP_ID; // [RULE5]
        express_word.next_link = bridge_cap_pkg::EXPRESS_NEXT_LINK; // [RULE6]
        if (reverse_active) begin
            express_word.port_type =
                bridge_cap_pkg::PORT_CONV_TO_EXPRESS; // [RULE7]
            express_word.slot_implemented =
                bridge_cap_pkg::SLOT_REVERSE; // [RULE9]
        end else begin
            express_word.port_type =
                bridge_cap_pkg::PORT_EXPRESS_TO_CONV; // [RULE8]
            express_word.slot_implemented =
                bridge_cap_pkg::SLOT_FORWARD; // [RULE9]
        end
    end

    always_comb begin
        control_word = 32'h0000_0000;
        control_word[bridge_cap_pkg::CTRL_SLOT_IDENT_BIT] = slot_ident_en;
    end

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[bridge_cap_pkg::STATUS_REVERSE_BIT] = reverse_active;
        status_word[bridge_cap_pkg::STATUS_LATCHED_BIT] = strap_latched;
    end

    // Read select; writes to capability words fall through unused
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_slverr = 1'b0;
        unique case (paddr)
            bridge_cap_pkg::SUBSYS_CAP_OFFSET: next_rdata = subsys_word;
            bridge_cap_pkg::SUBSYS_ID_OFFSET: next_rdata = subsys_id_word;
            bridge_cap_pkg::EXPRESS_CAP_OFFSET: next_rdata = express_word;
            bridge_cap_pkg::CAP_CONTROL_OFFSET: next_rdata = control_word;
            bridge_cap_pkg::CAP_STATUS_OFFSET: next_rdata = status_word;
            default: next_slverr = 1'b1;
        endcase
        if (pwrite) begin
            next_rdata = 32'h0000_0000; // [RULE10]
        end
    end

    // Bus state: answer one cycle after setup
    always_comb begin
        next_bus_state = bus_state;
        unique case (bus_state)
            bridge_cap_pkg::BUS_IDLE: begin
                if (setup_phase) begin
                    next_bus_state = bridge_cap_pkg::BUS_ANSWER;
                end
            end
            bridge_cap_pkg::BUS_ANSWER: begin
                if (access_done) begin
                    next_bus_state = bridge_cap_pkg::BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_state <= bridge_cap_pkg::BUS_IDLE;
        end else begin
            bus_state <= next_bus_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (bus_state == bridge_cap_pkg::BUS_IDLE && setup_phase)
        begin
            pready <= 1'b1;
            pslverr <= next_slverr;
            prdata <= next_rdata;
        end else if (access_done) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic rd_ok;
    assign rd_ok = access_done && !pwrite && !pslverr;

    subsys_id_a: assert property ( // [RULE1]
        rd_ok && paddr == bridge_cap_pkg::SUBSYS_CAP_OFFSET
        |-> prdata[7:0] == 8'h0d && prdata[31:16] == 16'h0000)
        else $error("subsystem subsys_cap_identifier wrong");

    next_link_a: assert property ( // [RULE2]
        rd_ok && paddr == bridge_cap_pkg::SUBSYS_CAP_OFFSET
        |-> prdata[15:8] == (slot_ident_en ? 8'ha0 : 8'hb0))
        else $error("subsystem next link wrong");

    vendor_code_a: assert property ( // [RULE3]
        rd_ok && paddr == bridge_cap_pkg::SUBSYS_ID_OFFSET
        |-> prdata[15:0] == SUBSYS_VENDOR_CODE)
        else $error("subsystem vendor code wrong");

    subsys_code_a: assert property ( // [RULE4]
        rd_ok && paddr == bridge_cap_pkg::SUBSYS_ID_OFFSET
        |-> prdata[31:16] == SUBSYS_CODE)
        else $error("subsystem code wrong");

    express_id_a: assert property ( // [RULE5]
        rd_ok && paddr == bridge_cap_pkg::EXPRESS_CAP_OFFSET
        |-> prdata[7:0] == 8'h10)
        else $error("express subsys_cap_identifier wrong");

    express_next_a: assert property ( // [RULE6]
        rd_ok && paddr == bridge_cap_pkg::EXPRESS_CAP_OFFSET
        |-> prdata[15:8] == 8'hf0)
        else $error("express next link wrong");

    port_code_a: assert property ( // [RULE7]
        express_word.port_type inside {4'h7, 4'h8})
        else $error("port type uses a reserved code");

    port_type_a: assert property ( // [RULE8]
        rd_ok && paddr == bridge_cap_pkg::EXPRESS_CAP_OFFSET
        |-> prdata[23:20] == (reverse_active ? 4'h8 : 4'h7))
        else $error("port type does not follow strap");

    slot_impl_a: assert property ( // [RULE9]
        rd_ok && paddr == bridge_cap_pkg::EXPRESS_CAP_OFFSET
        |-> prdata[24] == reverse_active)
        else $error("slot implemented does not follow strap");

    write_ignored_a: assert property ( // [RULE10]
        write_done && paddr != bridge_cap_pkg::CAP_CONTROL_OFFSET
        |=> $stable(subsys_word) && $stable(express_word)
            && $stable(subsys_id_word))
        else $error("write changed a capability field");

    reserved_zero_a: assert property ( // [RULE11]
        rd_ok && paddr == bridge_cap_pkg::EXPRESS_CAP_OFFSET
        |-> prdata[31:25] == 7'h00 && prdata[19:16] == 4'h1)
        else $error("express reserved or version wrong");

    strap_hold_a: assert property (
        strap_latched |=> $stable(reverse_active) && strap_latched)
        else $error("strap changed after capture");

    answer_time_a: assert property (
        bus_state == bridge_cap_pkg::BUS_IDLE && setup_phase
        |=> pready ##1 !pready)
        else $error("answer not one cycle after setup");

    reverse_read_c: cover property (
        rd_ok && reverse_active
        && paddr == bridge_cap_pkg::EXPRESS_CAP_OFFSET);

    slot_ident_c: cover property (
        rd_ok && slot_ident_en
        && paddr == bridge_cap_pkg::SUBSYS_CAP_OFFSET);

    ignored_write_c: cover property (
        write_done && paddr == bridge_cap_pkg::EXPRESS_CAP_OFFSET);

    unmapped_c: cover property (access_done && pslverr);

endmodule

// ==== test/bridge_capability_headers_tb.sv ====
`timescale 1ns/10ps
module bridge_capability_headers_tb;
    // Arbitrary identity values
    localparam logic [15:0] VENDOR = 16'h2b61;
    localparam logic [15:0] SUBSYS = 16'h7e04;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic reverse_strap;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [3:0] pstrb;
    logic pready;
    logic pslverr;
    logic err;
    logic reverse_active;
    logic slot_ident_active;
    int n_fail = 0;
    int num_checks = 0;

    bridge_capability_headers #(
        .SUBSYS_VENDOR_CODE(VENDOR),
        .SUBSYS_CODE(SUBSYS)
    ) DUT (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .reverse_strap(reverse_strap),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .reverse_active(reverse_active),
        .slot_ident_active(slot_ident_active)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer, entered right after a rising edge
    task automatic apb(input logic wr, input logic [7:0] addr,
                       input logic [31:0] data, input logic [3:0] strb);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        pstrb <= strb;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_fail++;
            $display("ERROR pready expected 1 seen timeout");
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input string name, input logic [7:0] addr,
                        input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000, 4'h0);
        check(name, exp, rd);
        check({name, " pslverr"}, 32'h0, {31'h0, err});
    endtask

    task automatic test_reset_values;
        check("slot_ident_active", 32'h0, {31'h0, slot_ident_active});
        check("reverse_active", 32'h0, {31'h0, reverse_active});
        rchk("word a8", 8'ha8, 32'h0000_b00d);
        rchk("word ac", 8'hac, {SUBSYS, VENDOR});
        rchk("word b0 fwd", 8'hb0, 32'h0071_f010);
        check("b0 fwd port", 32'h7, {28'h0, rd[23:20]});
        check("b0 fwd slot", 32'h0, {31'h0, rd[24]});
        rchk("status fwd", 8'hc4, 32'h0000_0002);
    endtask

    task automatic test_writes_ignored(input logic [31:0] b0_exp);
        logic [7:0] addrs [3] = '{8'ha8, 8'hac, 8'hb0};
        logic [31:0] exps [3];
        exps = '{32'h0000_b00d, {SUBSYS, VENDOR}, b0_exp};
        foreach (addrs[k]) begin
            apb(1'b1, addrs[k], 32'hffff_ffff, 4'hf);
            check("write pslverr", 32'h0, {31'h0, err});
            check("write prdata", 32'h0, rd);
            apb(1'b1, addrs[k], 32'h0000_0000, 4'hf);
            rchk("word after write", addrs[k], exps[k]);
        end
    endtask

    task automatic test_slot_ident;
        apb(1'b1, 8'hc0, 32'h0000_0001, 4'h0);
        rchk("a8 strobe off", 8'ha8, 32'h0000_b00d);
        apb(1'b1, 8'hc0, 32'h0000_0001, 4'h1);
        repeat (3) @(posedge pclk);
        check("slot_ident_active", 32'h1, {31'h0, slot_ident_active});
        rchk("control on", 8'hc0, 32'h0000_0001);
        rchk("a8 slot ident", 8'ha8, 32'h0000_a00d);
        apb(1'b1, 8'ha8, 32'h0000_b0ff, 4'hf);
        rchk("a8 after write", 8'ha8, 32'h0000_a00d);
        apb(1'b1, 8'hc0, 32'h0000_0000, 4'h1);
        rchk("a8 slot off", 8'ha8, 32'h0000_b00d);
    endtask

    task automatic test_unmapped;
        apb(1'b0, 8'h40, 32'h0000_0000, 4'h0);
        check("unmapped read pslverr", 32'h1, {31'h0, err});
        check("unmapped read data", 32'h0, rd);
        apb(1'b1, 8'hfc, 32'h1234_5678, 4'hf);
        check("unmapped write pslverr", 32'h1, {31'h0, err});
    endtask

    task automatic test_reverse;
        reverse_strap <= 1'b1;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        check("reverse_active", 32'h1, {31'h0, reverse_active});
        rchk("word b0 rev", 8'hb0, 32'h0181_f010);
        rchk("status rev", 8'hc4, 32'h0000_0003);
        test_writes_ignored(32'h0181_f010);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        reverse_strap = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        test_reset_values();
        test_writes_ignored(32'h0071_f010);
        test_slot_ident();
        test_unmapped();
        test_reverse();
        finish_test();
    end
endmodule
